// file: core/boot_flash_link_controller.sv
// boot memory, flash link control register and flash read window behind one apb slave
// assumes an apb4 master on pclk and one serial flash on the link pins
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module boot_flash_link_controller
    import boot_flash_pkg::*;
#(
    parameter int MEM_WORDS = 8192,
    parameter bit LEAD_CORE = 1'b1,
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb,
    output apb_rsp_t rsp,
    output logic flash_sclk,
    output logic flash_mosi,
    output logic flash_cs_n,
    input wire logic flash_miso
);
    // ====================================================================
    // storage and state
    logic [31:0] mem [MEM_WORDS];
    ctrl_t ctrl, next_ctrl;
    seq_state_t state, next_state;
    apb_rsp_t next_rsp;
    logic next_cs_n, eng_start, next_eng_start, eng_done, eng_busy;
    logic [7:0] eng_byte, next_eng_byte, eng_rx;
    logic [9:0] tx_idx, next_tx_idx;
    logic [1:0] sub, next_sub;
    logic [23:0] flash_off, next_flash_off;
    logic [31:0] rdata, next_rdata, win_off;
    logic access, in_mem, ctrl_hit, win_hit, in_region, wr_done;
    logic [12:0] widx;

    function automatic logic [7:0] buf_byte(input logic [9:0] idx);
        logic [14:0] a;
        a = BUF_BASE + {5'h00, idx};
        return mem[a[14:2]][8 * a[1:0] +: 8];
    endfunction : buf_byte

    // ====================================================================
    // decode
    always_comb begin
        access = apb.psel & apb.penable;
        in_mem = apb.paddr < MEM_BYTES;
        ctrl_hit = LEAD_CORE && (apb.paddr == CTRL_ADDR);
        win_hit = LEAD_CORE && (apb.paddr >= FLASH_BASE) && (apb.paddr <= FLASH_TOP);
        in_region = apb.paddr <= REGION_LAST;
        widx = apb.paddr[14:2];
        win_off = apb.paddr - FLASH_BASE;
        wr_done = access & rsp.pready & apb.pwrite & ~rsp.pslverr;
    end

    // ====================================================================
    // bus answers and sequencer
    always_comb begin
        next_rsp = rsp;
        next_rsp.pready = 1'b0;
        next_ctrl = ctrl;
        next_state = state;
        next_cs_n = flash_cs_n;
        next_eng_start = 1'b0;
        next_eng_byte = eng_byte;
        next_tx_idx = tx_idx;
        next_sub = sub;
        next_flash_off = flash_off;
        next_rdata = rdata;
        if (access && !rsp.pready) begin
            if (in_mem) begin
                next_rsp = '{prdata: mem[widx], pready: 1'b1, pslverr: 1'b0};
            end else if (ctrl_hit) begin
                if (state == S_IDLE) begin
                    next_rsp = '{prdata: ctrl & CTRL_RW_MASK, pready: 1'b1, pslverr: 1'b0};
                end
            end else if (win_hit && apb.pwrite) begin
                next_rsp = '{prdata: 32'h0000_0000, pready: 1'b1, pslverr: 1'b1};
            end else if (win_hit) begin
                if (state == S_IDLE) begin
                    next_state = S_RCMD;
                    next_cs_n = 1'b0;
                    next_eng_start = 1'b1;
                    next_eng_byte = ctrl.flash_read_opcode;
                    next_flash_off = win_off[23:0];
                end
            end else begin
                // unmapped, inside the boot region or not, answers with an error
                next_rsp = '{prdata: 32'h0000_0000, pready: 1'b1, pslverr: 1'b1};
            end
        end
        if (wr_done && ctrl_hit) begin
            for (int b = 0; b < 4; b++) begin
                if (apb.pstrb[b]) begin
                    next_ctrl[8 * b +: 8] = apb.pwdata[8 * b +: 8] & CTRL_RW_MASK[8 * b +: 8];
                end
            end
            if ((apb.pstrb[1:0] != 2'b00) && (next_ctrl.transmit_byte_count != 10'h000)) begin
                next_state = S_TX;
                next_cs_n = 1'b0;
                next_tx_idx = 10'h000;
                next_eng_start = 1'b1;
                next_eng_byte = buf_byte(10'h000);
            end
        end
        case (state)
            S_TX: begin
                if (eng_done) begin
                    if (tx_idx + 10'h001 == ctrl.transmit_byte_count) begin
                        next_state = S_IDLE;
                        next_cs_n = 1'b1;
                    end else begin
                        next_tx_idx = tx_idx + 10'h001;
                        next_eng_start = 1'b1;
                        next_eng_byte = buf_byte(tx_idx + 10'h001);
                    end
                end
            end
            S_RCMD: begin
                if (eng_done) begin
                    next_state = S_RADR;
                    next_sub = 2'h0;
                    next_eng_start = 1'b1;
                    next_eng_byte = flash_off[23:16];
                end
            end
            S_RADR: begin
                if (eng_done) begin
                    next_eng_start = 1'b1;
                    if (sub == ADDR_BYTES - 2'h1) begin
                        next_state = S_RDAT;
                        next_sub = 2'h0;
                        next_eng_byte = 8'h00;
                    end else begin
                        next_sub = sub + 2'h1;
                        next_eng_byte = (sub == 2'h0) ? flash_off[15:8] : flash_off[7:0];
                    end
                end
            end
            S_RDAT: begin
                if (eng_done) begin
                    next_rdata[8 * sub +: 8] = eng_rx;
                    if (sub == DATA_BYTES) begin
                        next_state = S_RET;
                        next_cs_n = 1'b1;
                    end else begin
                        next_sub = sub + 2'h1;
                        next_eng_start = 1'b1;
                        next_eng_byte = 8'h00;
                    end
                end
            end
            S_RET: begin
                next_state = S_IDLE;
                next_rsp = '{prdata: rdata, pready: 1'b1, pslverr: 1'b0};
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
            ctrl <= CTRL_RESET;
            state <= S_IDLE;
            flash_cs_n <= 1'b1;
            eng_start <= 1'b0;
            eng_byte <= 8'h00;
            tx_idx <= 10'h000;
            sub <= 2'h0;
            flash_off <= 24'h00_0000;
            rdata <= 32'h0000_0000;
        end else begin
            rsp <= next_rsp;
            ctrl <= next_ctrl;
            state <= next_state;
            flash_cs_n <= next_cs_n;
            eng_start <= next_eng_start;
            eng_byte <= next_eng_byte;
            tx_idx <= next_tx_idx;
            sub <= next_sub;
            flash_off <= next_flash_off;
            rdata <= next_rdata;
        end
    end

    // storage carries no reset: contents are undefined until software loads them
    always_ff @(posedge pclk) begin
        if (wr_done && in_mem) begin
            for (int b = 0; b < 4; b++) begin
                if (apb.pstrb[b]) begin
                    mem[widx][8 * b +: 8] <= apb.pwdata[8 * b +: 8];
                end
            end
        end
    end

    // ====================================================================
    // serial engine
    flash_shift_engine #(.HALF_CYC(HALF_CYC)) u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .start(eng_start),
        .tx_byte(eng_byte),
        .miso(flash_miso),
        .sclk(flash_sclk),
        .mosi(flash_mosi),
        .done(eng_done),
        .busy(eng_busy),
        .rx_byte(eng_rx)
    );

    // ====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_ctrl_write;
        access && rsp.pready && apb.pwrite && !rsp.pslverr && ctrl_hit;
    endsequence
    sequence seq_win_read;
        access && !rsp.pready && win_hit && !apb.pwrite && state == S_IDLE;
    endsequence

    chk_ctrl_store: assert property ((seq_ctrl_write and (apb.pstrb == 4'hF)) |=>
        ctrl == ($past(apb.pwdata) & CTRL_RW_MASK)) else $error("control write not stored");
    // both low lanes written, so the new count is wholly known from the write data
    chk_tx_launch: assert property ((seq_ctrl_write and
        (apb.pstrb[1:0] == 2'b11 && apb.pwdata[9:0] != 10'h000))
        |=> state == S_TX && !flash_cs_n ##1 eng_busy) else $error("transmit not launched");
    chk_tx_count: assert property (state == S_TX && eng_done &&
        tx_idx + 10'h001 == ctrl.transmit_byte_count |=> state == S_IDLE && flash_cs_n)
        else $error("transmit length wrong");
    chk_tx_data: assert property (state == S_TX && eng_start |->
        eng_byte == buf_byte(tx_idx)) else $error("transmit byte not from buffer");
    chk_opcode_first: assert property (seq_win_read |=>
        state == S_RCMD && eng_start && eng_byte == $past(ctrl.flash_read_opcode))
        else $error("opcode not sent first");
    chk_addr_byte: assert property (state == S_RCMD && eng_done |=>
        state == S_RADR && eng_byte == flash_off[23:16]) else $error("offset byte wrong");
    chk_mem_read: assert property (access && !rsp.pready && in_mem && !apb.pwrite |=>
        rsp.pready && !rsp.pslverr) else $error("memory read not answered");
    chk_region_err: assert property (access && !rsp.pready && !in_region |=>
        rsp.pready && rsp.pslverr) else $error("out of region not refused");
    chk_hold_off: assert property (access && win_hit && state inside {S_TX, S_RCMD, S_RADR}
        |=> !rsp.pready [*2]) else $error("window access not held off");
endmodule : boot_flash_link_controller

// file: core/boot_flash_pkg.sv
// constants, carriers and state codes for the boot memory and serial flash link controller
// assumes a 32-bit apb4 master on pclk and a mode 0 serial flash on the far side
package boot_flash_pkg;
    // ====================================================================
    // address map
    localparam logic [31:0] MEM_BYTES = 32'h0000_8000;
    localparam logic [14:0] BUF_BASE = 15'h7C00;
    localparam logic [31:0] CTRL_ADDR = 32'h0100_0000;
    localparam logic [31:0] FLASH_BASE = 32'h2000_0000;
    localparam logic [31:0] FLASH_TOP = 32'h3FFF_FFFF;
    localparam logic [31:0] REGION_LAST = 32'h3FFF_FFFF;
    // ====================================================================
    // control register layout
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RW_MASK = 32'h00FF_03FF;
    localparam int CNT_LSB = 0;
    localparam int CNT_W = 10;
    localparam int CMD_LSB = 16;
    localparam int CMD_W = 8;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [1:0] DATA_BYTES = 2'h3;
    // ====================================================================
    // timing
    localparam int PCLK_NS = 40;
    localparam int SCLK_HALF_NS = 160;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
    localparam logic [2:0] BITS_LAST = 3'h7;
    // ====================================================================
    // carriers
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic [7:0] unused_hi;
        logic [7:0] flash_read_opcode;
        logic [5:0] unused_mid;
        logic [9:0] transmit_byte_count;
    } ctrl_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_TX = 3'h1,
        S_RCMD = 3'h3,
        S_RADR = 3'h2,
        S_RDAT = 3'h6,
        S_RET = 3'h7
    } seq_state_t;
endpackage : boot_flash_pkg

// file: core/flash_shift_engine.sv
// one-byte mode 0 shifter toward the serial flash, msb first
// assumes start is only pulsed while busy is low; miso arrives from outside the pclk domain
`timescale 1ns/10ps
module flash_shift_engine
    import boot_flash_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic done,
    output logic busy,
    output logic [7:0] rx_byte
);
    // ====================================================================
    // state
    logic s1, s2, s3, miso_f;
    logic next_s1, next_s2, next_s3, next_miso_f;
    logic next_sclk, next_mosi, next_done, next_busy;
    logic [7:0] sh, next_sh, next_rx_byte, div, next_div;
    logic [2:0] bits, next_bits;

    always_comb begin
        next_s1 = miso;
        next_s2 = s1;
        next_s3 = s2;
        next_miso_f = (s2 == s3) ? s3 : miso_f;
        next_sclk = sclk;
        next_mosi = mosi;
        next_done = 1'b0;
        next_busy = busy;
        next_sh = sh;
        next_rx_byte = rx_byte;
        next_div = div;
        next_bits = bits;
        if (!busy) begin
            if (start) begin
                next_busy = 1'b1;
                next_sh = tx_byte;
                next_mosi = tx_byte[7];
                next_sclk = 1'b0;
                next_div = 8'h00;
                next_bits = 3'h0;
            end
        end else if (div == 8'(HALF_CYC - 1)) begin
            next_div = 8'h00;
            if (!sclk) begin
                next_sclk = 1'b1;
            end else begin
                // filtered miso lags the pin by about four cycles, so sampling here
                // reads the level that stood as sclk rose, at the start of the high phase
                next_sclk = 1'b0;
                next_rx_byte = {rx_byte[6:0], miso_f};
                if (bits == BITS_LAST) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_bits = bits + 3'h1;
                    next_sh = {sh[6:0], 1'b0};
                    next_mosi = sh[6];
                end
            end
        end else begin
            next_div = div + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            miso_f <= 1'b0;
            sclk <= 1'b0;
            mosi <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            sh <= 8'h00;
            rx_byte <= 8'h00;
            div <= 8'h00;
            bits <= 3'h0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            miso_f <= next_miso_f;
            sclk <= next_sclk;
            mosi <= next_mosi;
            done <= next_done;
            busy <= next_busy;
            sh <= next_sh;
            rx_byte <= next_rx_byte;
            div <= next_div;
            bits <= next_bits;
        end
    end
endmodule : flash_shift_engine

// file: test/flash_model.sv
// behavioural serial flash on the link pins: records each frame, answers reads
// assumes mode 0, msb first, one frame for each chip-select low period
`timescale 1ns/10ps
module flash_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso
);
    // ====================================================================
    // frame capture
    logic [7:0] sh;
    logic [7:0] b;
    logic [7:0] rx_q[$];
    int nbit;
    int k;
    initial begin
        miso = 1'b0;
        sh = 8'h00;
        nbit = 0;
    end
    always @(negedge cs_n) begin
        rx_q.delete();
        nbit = 0;
    end
    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[6:0], mosi};
            nbit++;
            if (nbit % 8 == 0) begin
                rx_q.push_back(sh);
            end
        end
    end
    // ====================================================================
    // read data: byte k is the low offset byte plus k plus one
    // an undriven line toggles so that a stale bit can never look right
    always @(negedge sclk or posedge cs_n) begin
        if (!cs_n && nbit >= 32) begin
            k = (nbit - 32) / 8;
            b = rx_q[3] + 8'(k + 1);
            miso = b[7 - nbit % 8];
        end else begin
            miso = ~miso;
        end
    end
endmodule : flash_model

// file: test/boot_flash_link_controller_tb_top.sv
// self-checking bench for the boot memory and flash link controller
// assumes the flash model on the link pins; this module is the apb master
`timescale 1ns/10ps
module boot_flash_link_controller_tb_top;
    import boot_flash_pkg::*;
    // ====================================================================
    // clock, reset and wiring
    localparam int LIMIT = 20000;
    logic pclk;
    logic presetn;
    apb_req_t apb;
    apb_rsp_t rsp;
    logic flash_sclk;
    logic flash_mosi;
    logic flash_cs_n;
    logic flash_miso;
    apb_rsp_t rsp_follow;
    logic follow_cs_n;
    int n_fail;
    int checked;
    int cycles;
    boot_flash_link_controller #(.HALF_CYC(4)) DUT (
        .pclk(pclk),
        .presetn(presetn),
        .apb(apb),
        .rsp(rsp),
        .flash_sclk(flash_sclk),
        .flash_mosi(flash_mosi),
        .flash_cs_n(flash_cs_n),
        .flash_miso(flash_miso)
    );
    // a follower core sees the same bus but owns no flash link
    boot_flash_link_controller #(.HALF_CYC(4), .LEAD_CORE(1'b0)) DUT_FOLLOW (
        .pclk(pclk),
        .presetn(presetn),
        .apb(apb),
        .rsp(rsp_follow),
        .flash_sclk(),
        .flash_mosi(),
        .flash_cs_n(follow_cs_n),
        .flash_miso(1'b0)
    );
    flash_model flash (
        .sclk(flash_sclk),
        .mosi(flash_mosi),
        .cs_n(flash_cs_n),
        .miso(flash_miso)
    );
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // a window read takes some 525 cycles; the limit leaves wide margin
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            wrap_up();
        end
    end
    // ====================================================================
    // shared tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic e);
        apb.paddr <= a;
        apb.pwrite <= w;
        apb.pwdata <= d;
        apb.pstrb <= s;
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        @(posedge pclk);
        apb.penable <= 1'b1;
        // only the bench timeout ends a wait that never finishes
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        e = rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    // ====================================================================
    // scenarios
    task automatic t_ctrl_reg();
        logic [31:0] rd;
        logic e;
        xfer(CTRL_ADDR, 1'b0, 32'h0, 4'hF, rd, e);
        check(rd, 32'h0000_0000);
        check(rsp_follow.pslverr, 1'b1);
        xfer(CTRL_ADDR, 1'b1, 32'hFFFF_FFFF, 4'hC, rd, e);
        xfer(CTRL_ADDR, 1'b0, 32'h0, 4'hF, rd, e);
        check(rd, 32'h00FF_0000);
        check(flash_cs_n, 1'b1);
        xfer(CTRL_ADDR, 1'b1, 32'h0, 4'hF, rd, e);
        repeat (10) @(posedge pclk);
        check(flash_cs_n, 1'b1);
    endtask : t_ctrl_reg
    task automatic t_memory();
        logic [31:0] rd;
        logic e;
        xfer(32'h0, 1'b1, 32'hA5A5_0001, 4'hF, rd, e);
        xfer(32'h7FFC, 1'b1, 32'h5A5A_7FFC, 4'hF, rd, e);
        xfer(32'h0, 1'b0, 32'h0, 4'hF, rd, e);
        check(rd, 32'hA5A5_0001);
        xfer(32'h7FFC, 1'b0, 32'h0, 4'hF, rd, e);
        check(rd, 32'h5A5A_7FFC);
        xfer(32'h8000, 1'b0, 32'h0, 4'hF, rd, e);
        check({rd[30:0], e}, 32'h1);
        xfer(32'h4000_0000, 1'b0, 32'h0, 4'hF, rd, e);
        check(e, 1'b1);
        xfer(FLASH_BASE, 1'b1, 32'h1, 4'hF, rd, e);
        check(e, 1'b1);
    endtask : t_memory
    task automatic t_transmit();
        logic [31:0] rd;
        logic e;
        xfer(32'h7C00, 1'b1, 32'h4433_2211, 4'hF, rd, e);
        xfer(32'h7C04, 1'b1, 32'h8877_6655, 4'hF, rd, e);
        xfer(CTRL_ADDR, 1'b1, 32'h0003_0005, 4'hF, rd, e);
        // the read is held off until the last byte is out
        xfer(CTRL_ADDR, 1'b0, 32'h0, 4'hF, rd, e);
        check(rd, 32'h0003_0005);
        check(flash_cs_n, 1'b1);
        check(flash.rx_q.size(), 5);
        for (int i = 0; i < flash.rx_q.size(); i++) begin
            check(flash.rx_q[i], 8'h11 * (i + 1));
        end
    endtask : t_transmit
    task automatic t_window();
        logic [7:0] ops[10] = '{8'h05, 8'h35, 8'h15, 8'h03, 8'hAB,
                                8'h90, 8'h0B, 8'h4B, 8'h5A, 8'h48};
        logic [31:0] rd;
        logic [31:0] a;
        logic [23:0] off;
        logic [7:0] b;
        logic e;
        for (int i = 0; i < 10; i++) begin
            // software keeps to the supported opcodes
            xfer(CTRL_ADDR, 1'b1, {8'h00, ops[i], 16'h0000}, 4'h4, rd, e);
            a = (i == 0) ? 32'h3FFF_FFFC : FLASH_BASE + 32'h0001_2340 + 32'(i * 4);
            off = 24'(a - FLASH_BASE);
            b = off[7:0];
            xfer(a, 1'b0, 32'h0, 4'hF, rd, e);
            check(e, 1'b0);
            check(flash.rx_q.size(), 8);
            check(flash.rx_q[0], ops[i]);
            check({flash.rx_q[1], flash.rx_q[2], flash.rx_q[3]}, off);
            check(rd, {b + 8'h04, b + 8'h03, b + 8'h02, b + 8'h01});
            check(follow_cs_n, 1'b1);
        end
    endtask : t_window
    // ====================================================================
    // main sequence
    initial begin
        apb = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        check({flash_cs_n, flash_sclk, rsp.pready}, 3'h4);
        presetn <= 1'b1;
        @(posedge pclk);
        t_ctrl_reg();
        t_memory();
        t_transmit();
        t_window();
        wrap_up();
    end
endmodule : boot_flash_link_controller_tb_top
